// >>> verilog/rwc_consts.svh
// constants for the reset and watchdog controller
// assumes inclusion by bare name from design files
`ifndef RWC_CONSTS_SVH
`define RWC_CONSTS_SVH
`define RWC_ADDR_CTRL 8'h00
`define RWC_ADDR_STAT 8'h04
`define RWC_ADDR_MISC 8'h08
`define RWC_ADDR_RESTART 8'h0c
`define RWC_BIT_IRQ_FLAG 7
`define RWC_BIT_IRQ_EN 6
`define RWC_BIT_PS3 5
`define RWC_BIT_CHG_EN 4
`define RWC_BIT_RST_EN 3
`define RWC_BIT_RESET_FLAG 0
`define RWC_BIT_COMPARATOR_BANDGAP_SELECT 0
`define RWC_BIT_ADC_EN 1
`define RWC_BIT_SCAN_RST 2
`define RWC_BIT_IRQ_ACK 3
`define RWC_CHG_WINDOW 3'h4
`define RWC_PS_MAX 4'h9
`define RWC_BASE_CYCLES 2048
`define RWC_CLK_MHZ 125
`define RWC_DELAY_US 65
`define RWC_DELAY_CYC ((`RWC_DELAY_US * `RWC_CLK_MHZ))
`endif

// >>> verilog/rwc_pkg.sv
// types for the reset and watchdog controller
// assumes nothing beyond the compile order
package rwc_pkg;
    typedef enum logic [2:0] {
        RWC_RUN = 3'b001,
        RWC_HOLD = 3'b010,
        RWC_STRETCH = 3'b100
    } rwc_rst_e;
endpackage

// >>> verilog/rwc_wdog_core.sv
// watchdog counter on the 128 kHz oscillator domain
// assumes restart and expiry cross as toggles, prescale is quasi-static
`timescale 1ns/1ps
`default_nettype none
module rwc_wdog_core
#(
    parameter int CNT_W = 21,
    parameter int BASE = 2048
)
(
    input wire logic i_wclk,
    input wire logic i_rst,
    input wire logic i_run,
    input wire logic [3:0] i_ps,
    input wire logic i_restart_tgl,
    output logic o_expire_tgl
);
    logic [CNT_W-1:0] cnt_q;
    logic run_s1_q, run_s2_q, rs1_q, rs2_q, rs3_q;
    logic [3:0] ps1_q, ps2_q;
    logic [CNT_W-1:0] limit;
    assign limit = CNT_W'(BASE) << ps2_q;
    always_ff @(posedge i_wclk or posedge i_rst)
        if (i_rst)
        begin
            run_s1_q <= 1'b0;
            run_s2_q <= 1'b0;
            rs1_q <= 1'b0;
            rs2_q <= 1'b0;
            rs3_q <= 1'b0;
            ps1_q <= 4'h0;
            ps2_q <= 4'h0;
        end
        else
        begin
            run_s1_q <= i_run;
            run_s2_q <= run_s1_q;
            rs1_q <= i_restart_tgl;
            rs2_q <= rs1_q;
            rs3_q <= rs2_q;
            ps1_q <= i_ps;
            ps2_q <= ps1_q;
        end
    // counts oscillator cycles, restarts on request
    always_ff @(posedge i_wclk or posedge i_rst)
        if (i_rst)
        begin
            cnt_q <= '0;
            o_expire_tgl <= 1'b0;
        end
        else if (!run_s2_q || (rs2_q ^ rs3_q))
            cnt_q <= '0;
        else if (cnt_q >= limit - CNT_W'(1))
        begin
            cnt_q <= '0;
            o_expire_tgl <= ~o_expire_tgl;
        end
        else
            cnt_q <= cnt_q + CNT_W'(1);
endmodule // rwc_wdog_core
`default_nettype wire

// >>> verilog/rwc_top.sv
// reset combiner, delay stretcher and watchdog control with an AHB-Lite slave
// assumes analog detector levels asynchronous, fuses static, one AHB master
//
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rwc_consts.svh"
// Notes on behaviour
// - reset loads registers, core restarts at vector
// - port pins forced asynchronously on level-source resets, one clock later on scan and watchdog reset
// - internal reset stretched after all sources release
// - reset is OR of five sources
// - long low on reset pin resets clocklessly
// - pin release starts the delay counter
// - power-on detect resets at once
// - enabled brown-out resets at once, delayed release
// - scan reset bit holds reset while one
// - watchdog reset pulse one clock long
// - reference on for brown-out, bandgap, ADC
// - watchdog counts 128 kHz oscillator cycles
// - restart clears counter; software restarts in time
// - interrupt mode raises interrupt only
// - reset mode expiry resets system
// - combined mode interrupts then becomes reset mode
// - always-on fuse forces reset mode
// - reset-enable clears and prescale changes accepted only within four cycles
// - time-out selectable 16 ms to 8 s
// - prescale codes zero to nine, rest reserved
// - change enable self-clears after four cycles
// - reset flag forces reset enable
// - interrupt flag sets on expiry, clears by ack
module rwc_top
#(
    parameter int DELAY_CYC = `RWC_DELAY_CYC
)
(
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_CE,
    input wire logic I_WDOG_CLK,
    input wire logic I_POWER_LOW,
    input wire logic I_RESET_PIN_N,
    input wire logic I_BROWNOUT_LOW,
    input wire logic [2:0] I_BROWNOUT_LEVEL_FUSES,
    input wire logic I_WATCHDOG_ALWAYS_ON_FUSE,
    input wire logic [5:0] I_STARTUP_SELECT,
    input wire logic I_WDOG_RESTART,
    input wire logic I_IRQ_VECTOR_TAKEN,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    output logic O_PORT_RESET,
    output logic O_CORE_RESET,
    output logic O_WDOG_IRQ,
    output logic O_VREF_EN
);
    logic ctrl_sel;
    logic stat_sel;
    logic misc_sel;
    logic rst_sel;
    logic scan_rst_q;
    logic comparator_bandgap_select_q;
    logic adc_en_q;
    logic irq_en_q;
    logic rst_en_q;
    logic chg_en_q;
    logic irq_flag_q;
    logic reset_flag_q;
    logic [3:0] ps_q;
    logic [2:0] chg_cnt_q;
    logic restart_tgl_q;
    logic expire_tgl;
    logic ex1_q;
    logic ex2_q;
    logic ex3_q;
    logic expire;
    logic wd_pulse_q;
    logic pin_s1_q;
    logic pin_s2_q;
    logic raw_src;
    logic src_s1_q;
    logic src_s2_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] wdat;
    logic src_async;
    logic async_rst;
    logic wr_ctrl;
    logic eff_rst_en;
    logic eff_irq_en;
    logic [7:0] ctrl_view;
    logic [$clog2(DELAY_CYC+64)-1:0] dly_q;
    rwc_pkg::rwc_rst_e st_q;
    function automatic logic legal_ps(input logic [3:0] p);
        legal_ps = (p <= `RWC_PS_MAX);
    endfunction
    // write strobe for one register offset
    function automatic logic wr_hit(input logic pend, input logic [7:0] a, input logic [7:0] r);
        wr_hit = pend && (a == r);
    endfunction
    // level sources asynchronously reset the stretcher, port output and watchdog control
    assign raw_src = I_POWER_LOW | ~I_RESET_PIN_N
                     | ((I_BROWNOUT_LEVEL_FUSES != 3'h7) & I_BROWNOUT_LOW);
    assign src_async = src_s2_q | scan_rst_q;
    assign async_rst = I_RST | I_POWER_LOW | ~I_RESET_PIN_N
                       | ((I_BROWNOUT_LEVEL_FUSES != 3'h7) & I_BROWNOUT_LOW);
    assign wdat = HWDATA;
    assign wr_ctrl = ctrl_sel;
    // fuse and flag overrides on enables
    assign eff_rst_en = rst_en_q | I_WATCHDOG_ALWAYS_ON_FUSE | reset_flag_q;
    assign eff_irq_en = irq_en_q & ~I_WATCHDOG_ALWAYS_ON_FUSE;
    assign ctrl_view = {irq_flag_q, eff_irq_en, ps_q[3], chg_en_q, eff_rst_en, ps_q[2:0]};
    assign expire = ex2_q ^ ex3_q;
    rwc_wdog_core #(.CNT_W(21), .BASE(`RWC_BASE_CYCLES)) u_core
    (
        .i_wclk(I_WDOG_CLK),
        .i_rst(I_RST),
        .i_run(eff_rst_en | eff_irq_en),
        .i_ps(ps_q),
        .i_restart_tgl(restart_tgl_q),
        .o_expire_tgl(expire_tgl)
    );
    // pin released level synchronised before the stretcher looks at it
    always_ff @(posedge I_CLK or posedge async_rst)
        if (async_rst)
        begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
        end
        else if (I_CE)
        begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= pin_s1_q;
        end
    // raw detector level synchronised for the state machine
    always_ff @(posedge I_CLK or posedge I_RST)
        if (I_RST)
        begin
            src_s1_q <= 1'b0;
            src_s2_q <= 1'b0;
        end
        else if (I_CE)
        begin
            src_s1_q <= raw_src;
            src_s2_q <= src_s1_q;
        end
    // port pins follow level sources at once, scan and watchdog resets one clock later
    always_ff @(posedge I_CLK or posedge async_rst)
        if (async_rst)
            O_PORT_RESET <= 1'b1;
        else if (I_CE)
            O_PORT_RESET <= scan_rst_q | wd_pulse_q | (st_q != rwc_pkg::RWC_RUN);
    // stretch internal reset after release
    always_ff @(posedge I_CLK or posedge async_rst)
        if (async_rst)
        begin
            st_q <= rwc_pkg::RWC_HOLD;
            dly_q <= '0;
            O_CORE_RESET <= 1'b1;
        end
        else if (I_CE)
            unique case (st_q)
                rwc_pkg::RWC_RUN:
                begin
                    O_CORE_RESET <= src_async | wd_pulse_q;
                    if (src_async | wd_pulse_q)
                        st_q <= rwc_pkg::RWC_HOLD;
                end
                rwc_pkg::RWC_HOLD:
                begin
                    O_CORE_RESET <= 1'b1;
                    dly_q <= '0;
                    if (!src_async && !wd_pulse_q && pin_s2_q)
                        st_q <= rwc_pkg::RWC_STRETCH;
                end
                rwc_pkg::RWC_STRETCH:
                begin
                    O_CORE_RESET <= 1'b1;
                    if (src_async)
                        st_q <= rwc_pkg::RWC_HOLD;
                    else if (dly_q >= $bits(dly_q)'(DELAY_CYC - 1 + I_STARTUP_SELECT))
                    begin
                        st_q <= rwc_pkg::RWC_RUN;
                        O_CORE_RESET <= 1'b0;
                    end
                    else
                        dly_q <= dly_q + 1'b1;
                end
            endcase
    // expiry crossing and one-cycle watchdog reset
    always_ff @(posedge I_CLK or posedge I_RST)
        if (I_RST)
        begin
            ex1_q <= 1'b0;
            ex2_q <= 1'b0;
            ex3_q <= 1'b0;
            wd_pulse_q <= 1'b0;
        end
        else if (I_CE)
        begin
            ex1_q <= expire_tgl;
            ex2_q <= ex1_q;
            ex3_q <= ex2_q;
            wd_pulse_q <= expire & eff_rst_en & ~eff_irq_en;
        end
    // restart as toggle into oscillator domain
    always_ff @(posedge I_CLK or posedge I_RST)
        if (I_RST)
            restart_tgl_q <= 1'b0;
        else if (I_CE && (I_WDOG_RESTART || rst_sel))
            restart_tgl_q <= ~restart_tgl_q;
    // reset flag: set on watchdog reset, write zero clears, set wins
    always_ff @(posedge I_CLK or posedge I_RST)
        if (I_RST)
            reset_flag_q <= 1'b0;
        else if (I_CE)
        begin
            if (wd_pulse_q)
                reset_flag_q <= 1'b1;
            else if (stat_sel && !wdat[`RWC_BIT_RESET_FLAG])
                reset_flag_q <= 1'b0;
        end
    // misc control: scan reset, bandgap select, adc enable
    always_ff @(posedge I_CLK or posedge I_RST)
        if (I_RST)
        begin
            scan_rst_q <= 1'b0;
            comparator_bandgap_select_q <= 1'b0;
            adc_en_q <= 1'b0;
            O_VREF_EN <= 1'b0;
        end
        else if (I_CE)
        begin
            if (misc_sel)
            begin
                scan_rst_q <= wdat[`RWC_BIT_SCAN_RST];
                comparator_bandgap_select_q <= wdat[`RWC_BIT_COMPARATOR_BANDGAP_SELECT];
                adc_en_q <= wdat[`RWC_BIT_ADC_EN];
            end
            O_VREF_EN <= (I_BROWNOUT_LEVEL_FUSES != 3'h7) | comparator_bandgap_select_q | adc_en_q;
        end
    // timed change window
    always_ff @(posedge I_CLK or posedge async_rst)
        if (async_rst)
        begin
            chg_en_q <= 1'b0;
            chg_cnt_q <= 3'h0;
        end
        else if (I_CE)
        begin
            if (wr_ctrl && wdat[`RWC_BIT_CHG_EN] && wdat[`RWC_BIT_RST_EN])
            begin
                chg_en_q <= 1'b1;
                chg_cnt_q <= `RWC_CHG_WINDOW;
            end
            else if (wr_ctrl && chg_en_q)
            begin
                chg_en_q <= 1'b0;
                chg_cnt_q <= 3'h0;
            end
            else if (chg_cnt_q != 3'h0)
            begin
                chg_cnt_q <= chg_cnt_q - 3'h1;
                if (chg_cnt_q == 3'h1)
                    chg_en_q <= 1'b0;
            end
        end
    // control fields; clearing reset enable or changing prescale only in window
    always_ff @(posedge I_CLK or posedge async_rst)
        if (async_rst)
        begin
            irq_en_q <= 1'b0;
            rst_en_q <= 1'b0;
            ps_q <= 4'h0;
        end
        else if (I_CE)
        begin
            if (wr_ctrl)
            begin
                irq_en_q <= wdat[`RWC_BIT_IRQ_EN];
                if (wdat[`RWC_BIT_RST_EN])
                    rst_en_q <= 1'b1;
                else if (chg_en_q && !wdat[`RWC_BIT_CHG_EN] && !reset_flag_q)
                    rst_en_q <= 1'b0;
                if (chg_en_q && !wdat[`RWC_BIT_CHG_EN]
                    && legal_ps({wdat[`RWC_BIT_PS3], wdat[2:0]}))
                    ps_q <= {wdat[`RWC_BIT_PS3], wdat[2:0]};
            end
            else if (irq_flag_q && I_IRQ_VECTOR_TAKEN && rst_en_q)
                irq_en_q <= 1'b0;
        end
    // interrupt flag: set on expiry in irq modes, set wins over clear
    always_ff @(posedge I_CLK or posedge async_rst)
        if (async_rst)
        begin
            irq_flag_q <= 1'b0;
            O_WDOG_IRQ <= 1'b0;
        end
        else if (I_CE)
        begin
            if (expire && eff_irq_en)
                irq_flag_q <= 1'b1;
            else if (I_IRQ_VECTOR_TAKEN
                     || (wr_ctrl && wdat[`RWC_BIT_IRQ_FLAG])
                     || (stat_sel && wdat[`RWC_BIT_IRQ_ACK]))
                irq_flag_q <= 1'b0;
            O_WDOG_IRQ <= (irq_flag_q | (expire & eff_irq_en)) & eff_irq_en;
        end
    // AHB-Lite slave, zero wait states
    always_ff @(posedge I_CLK or posedge I_RST)
        if (I_RST)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            HRDATA <= 32'h0000_0000;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
        else if (I_CE)
        begin
            wr_pend_q <= HSEL & HREADY & HTRANS[1] & HWRITE;
            wr_addr_q <= HADDR[7:0];
            if (HSEL && HREADY && HTRANS[1] && !HWRITE)
            begin
                unique case (HADDR[7:0])
                    `RWC_ADDR_CTRL: HRDATA <= {24'h000000, ctrl_view};
                    `RWC_ADDR_STAT: HRDATA <= {31'h00000000, reset_flag_q};
                    `RWC_ADDR_MISC: HRDATA <= {29'h00000000, scan_rst_q, adc_en_q, comparator_bandgap_select_q};
                    default: HRDATA <= 32'h0000_0000;
                endcase
            end
        end
    assign ctrl_sel = wr_hit(wr_pend_q, wr_addr_q, `RWC_ADDR_CTRL);
    assign stat_sel = wr_hit(wr_pend_q, wr_addr_q, `RWC_ADDR_STAT);
    assign misc_sel = wr_hit(wr_pend_q, wr_addr_q, `RWC_ADDR_MISC);
    assign rst_sel = wr_hit(wr_pend_q, wr_addr_q, `RWC_ADDR_RESTART);
endmodule // rwc_top
`default_nettype wire

// >>> sim/rwc_monitor.sv
// port checker for the reset and watchdog controller
// assumes binding into rwc_top, one clock domain for the checks
`timescale 1ns/1ps
`default_nettype none
module rwc_monitor
#(
    parameter int DELAY_CYC = 8
)
(
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_CE,
    input wire logic I_POWER_LOW,
    input wire logic I_RESET_PIN_N,
    input wire logic I_BROWNOUT_LOW,
    input wire logic [2:0] I_BROWNOUT_LEVEL_FUSES,
    input wire logic I_WATCHDOG_ALWAYS_ON_FUSE,
    input wire logic I_IRQ_VECTOR_TAKEN,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic O_PORT_RESET,
    input wire logic O_CORE_RESET,
    input wire logic O_WDOG_IRQ,
    input wire logic O_VREF_EN
);
    logic bod_on;
    logic src;
    logic [7:0] rel_q;
    assign bod_on = I_BROWNOUT_LEVEL_FUSES != 3'h7;
    assign src = I_POWER_LOW | !I_RESET_PIN_N | (I_BROWNOUT_LOW & bod_on);
    // cycles since the last external source let go
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
            rel_q <= 8'h00;
        else if (src)
            rel_q <= 8'h00;
        else if (rel_q != 8'hff)
            rel_q <= rel_q + 8'h01;
    end
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);
    sequence s_early;
        rel_q < DELAY_CYC;
    endsequence
    sequence s_ack;
        I_IRQ_VECTOR_TAKEN && I_CE && O_WDOG_IRQ;
    endsequence
    property p_pin; !I_RESET_PIN_N |-> O_PORT_RESET; endproperty
    property p_por; I_POWER_LOW |-> O_PORT_RESET; endproperty
    property p_bod; I_BROWNOUT_LOW && bod_on |-> O_PORT_RESET; endproperty
    property p_stretch; s_early |-> O_CORE_RESET; endproperty
    property p_vref; bod_on |=> O_VREF_EN; endproperty
    property p_bus; HREADYOUT && !HRESP; endproperty
    property p_fuse; I_WATCHDOG_ALWAYS_ON_FUSE |-> !O_WDOG_IRQ; endproperty
    property p_ack; s_ack |=> ##[0:1] !O_WDOG_IRQ; endproperty
    a_pin: assert property (p_pin) else $error("pin low without port reset");
    a_por: assert property (p_por) else $error("power low without port reset");
    a_bod: assert property (p_bod) else $error("brown-out without port reset");
    a_stretch: assert property (p_stretch) else $error("core reset released early");
    a_vref: assert property (p_vref) else $error("reference off with detector on");
    a_bus: assert property (p_bus) else $error("bus stalled or errored");
    a_fuse: assert property (p_fuse) else $error("irq with always-on fuse");
    a_ack: assert property (p_ack) else $error("irq kept after vector");
endmodule // rwc_monitor
bind rwc_top rwc_monitor #(.DELAY_CYC(DELAY_CYC)) u_mon (.I_CLK(I_CLK), .I_RST(I_RST),
    .I_CE(I_CE), .I_POWER_LOW(I_POWER_LOW), .I_RESET_PIN_N(I_RESET_PIN_N),
    .I_BROWNOUT_LOW(I_BROWNOUT_LOW), .I_BROWNOUT_LEVEL_FUSES(I_BROWNOUT_LEVEL_FUSES),
    .I_WATCHDOG_ALWAYS_ON_FUSE(I_WATCHDOG_ALWAYS_ON_FUSE),
    .I_IRQ_VECTOR_TAKEN(I_IRQ_VECTOR_TAKEN), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .O_PORT_RESET(O_PORT_RESET), .O_CORE_RESET(O_CORE_RESET), .O_WDOG_IRQ(O_WDOG_IRQ),
    .O_VREF_EN(O_VREF_EN));
`default_nettype wire

// >>> sim/rwc_far_model.sv
// far side: watchdog oscillator and analog reset detectors
// assumes oscillator sped up to keep watchdog time-outs short
`timescale 1ns/1ps
`default_nettype none
module rwc_far_model
#(
    parameter int HALF_NS = 20
)
(
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [1:0] i_kind,
    input wire logic [3:0] i_len,
    output logic o_wdog_clk,
    output logic o_power_low,
    output logic o_reset_pin_n,
    output logic o_brownout_low
);
    logic [3:0] left_q = 4'h0;
    logic [1:0] kind_q = 2'h0;
    initial o_wdog_clk = 1'h0;
    // free-running oscillator, unrelated to the system clock
    always #(HALF_NS) o_wdog_clk = ~o_wdog_clk;
    always @(posedge i_clk)
    begin
        if (i_go)
        begin
            left_q <= i_len;
            kind_q <= i_kind;
        end
        else if (left_q != 4'h0)
            left_q <= left_q - 4'h1;
    end
    assign o_power_low = (left_q != 4'h0) && (kind_q == 2'h0);
    assign o_reset_pin_n = !((left_q != 4'h0) && (kind_q == 2'h1));
    assign o_brownout_low = (left_q != 4'h0) && (kind_q == 2'h2);
endmodule // rwc_far_model
`default_nettype wire

// >>> sim/reset_and_watchdog_control_tb.sv
// bench for the reset and watchdog controller
// assumes the far model drives detectors and the oscillator
`timescale 1ns/1ps
`default_nettype none
module reset_and_watchdog_control_tb;
    localparam int DLY = 8;
    logic clk = 1'h0, rst = 1'h1, aon = 1'h0, wrst = 1'h0, vtk = 1'h0, go = 1'h0;
    logic hsel = 1'h0, hwrite = 1'h0, hready, hresp, pwr, pin_n, brownout_detector, wclk;
    logic port_rst, core_rst, irq, vref;
    logic [1:0] htrans = 2'h0, kind = 2'h0;
    logic [2:0] fuses = 3'h7;
    logic [3:0] len = 4'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, cur = 32'h0;
    int err_count = 0, check_count = 0, seed = 32'h009155ae, i, n, k, p;
    always #4 clk = ~clk;
    rwc_top #(.DELAY_CYC(DLY)) u_dut (.I_CLK(clk), .I_RST(rst), .I_CE(1'h1), .I_WDOG_CLK(wclk),
        .I_POWER_LOW(pwr), .I_RESET_PIN_N(pin_n), .I_BROWNOUT_LOW(brownout_detector),
        .I_BROWNOUT_LEVEL_FUSES(fuses), .I_WATCHDOG_ALWAYS_ON_FUSE(aon),
        .I_STARTUP_SELECT(6'h00), .I_WDOG_RESTART(wrst), .I_IRQ_VECTOR_TAKEN(vtk),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
        .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
        .O_PORT_RESET(port_rst), .O_CORE_RESET(core_rst), .O_WDOG_IRQ(irq), .O_VREF_EN(vref));
    rwc_far_model u_far (.i_clk(clk), .i_go(go), .i_kind(kind), .i_len(len),
        .o_wdog_clk(wclk), .o_power_low(pwr), .o_reset_pin_n(pin_n), .o_brownout_low(brownout_detector));
    task automatic fail(input string m);
        err_count++;
        $display("unexpected %0t %s", $time, m);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
            fail($sformatf("got %h want %h", g, e));
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic tend(input int t);
        $display("test %0d done", t);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        k = 0;
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge clk);
        while (hready !== 1'h1 && k++ < 50) @(posedge clk);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'h1 && k++ < 50) @(posedge clk);
        if (k > 50)
            fail("bus timeout");
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'h1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        bus(1'h0, a, 32'h0);
        chk(q & m, e);
    endtask
    task automatic wt(input logic s, input logic v, input int lim);
        n = 0;
        while ((s ? irq : core_rst) !== v && n++ < lim) @(posedge clk);
        chk({31'h0, s ? irq : core_rst}, {31'h0, v});
    endtask
    task automatic cfg(input logic [31:0] v);
        wr(8'h00, (cur & 32'h27) | 32'h18);
        wr(8'h00, v);
        cur = v;
    endtask
    task automatic src(input logic [1:0] kd, input logic [3:0] ln);
        go <= 1'h1;
        kind <= kd;
        len <= ln;
        @(posedge clk);
        go <= 1'h0;
    endtask
    function automatic logic [31:0] cv(input logic ie, input logic re, input logic [3:0] ps);
        return {24'h0, 1'h0, ie, ps[3], 1'h0, re, ps[2:0]};
    endfunction
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        wt(1'h0, 1'h0, 300);
        rd(8'h00, 32'h0, 32'hf7);
        wr(8'h04, 32'h0);
        cfg(32'h0);
        for (i = 0; i < 16; i++)
        begin
            cfg(cv(1'h0, 1'h0, i[3:0]));
            rd(8'h00, cv(1'h0, 1'h0, (i > 9) ? 4'h9 : i[3:0]), 32'hff);
        end
        p = {$random(seed)} % 10;
        cfg(cv(1'h0, 1'h0, p[3:0]));
        wr(8'h00, cur | 32'h18);
        repeat (6) @(posedge clk);
        wr(8'h00, cv(1'h0, 1'h0, p[3:0] ^ 4'h1));
        rd(8'h00, cv(1'h0, 1'h1, p[3:0]), 32'hff);
        cur = cv(1'h0, 1'h1, p[3:0]);
        cfg(32'h0);
        for (i = 0; i < 4; i++)
        begin
            wr(8'h08, i);
            repeat (2) @(posedge clk);
            chk({31'h0, vref}, {31'h0, i != 0});
        end
        wr(8'h08, 32'h4);
        repeat (40) @(posedge clk);
        chk({31'h0, core_rst}, 32'h1);
        wr(8'h08, 32'h0);
        wt(1'h0, 1'h0, 100);
        tend(1);
        cfg(cv(1'h1, 1'h0, 4'h0));
        wt(1'h1, 1'h1, 12000);
        chk({31'h0, core_rst}, 32'h0);
        rd(8'h00, 32'h80, 32'h80);
        wr(8'h00, cv(1'h1, 1'h0, 4'h0) | 32'h80);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        for (i = 0; i < 30; i++)
        begin
            repeat (100 + {$random(seed)} % 800) @(posedge clk);
            wrst <= i[0];
            @(posedge clk);
            wrst <= 1'h0;
            if (!i[0])
                wr(8'h0c, 32'h0);
        end
        chk({31'h0, irq}, 32'h0);
        cfg(32'h0);
        cfg(cv(1'h0, 1'h1, 4'h0));
        wt(1'h0, 1'h1, 12000);
        wt(1'h0, 1'h0, 300);
        chk({31'h0, n >= DLY}, 32'h1);
        rd(8'h04, 32'h1, 32'h1);
        cfg(32'h0);
        rd(8'h00, cv(1'h0, 1'h1, 4'h0), 32'hff);
        wr(8'h04, 32'h0);
        cfg(32'h0);
        rd(8'h00, 32'h0, 32'hff);
        tend(2);
        cfg(cv(1'h1, 1'h1, 4'h0));
        wt(1'h1, 1'h1, 12000);
        chk({31'h0, core_rst}, 32'h0);
        vtk <= 1'h1;
        @(posedge clk);
        vtk <= 1'h0;
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        rd(8'h00, 32'h0, 32'hc0);
        wt(1'h0, 1'h1, 12000);
        wt(1'h0, 1'h0, 300);
        wr(8'h04, 32'h0);
        cfg(32'h0);
        tend(3);
        for (i = 0; i < 12; i++)
        begin
            p = i % 3;
            src(p[1:0], 4'(3 + {$random(seed)} % 10));
            @(posedge clk);
            chk({31'h0, port_rst}, {31'h0, p != 2});
            repeat (int'(len)) @(posedge clk);
            wt(1'h0, 1'h0, 100);
            chk({31'h0, (p == 2) ? (n == 0) : (n >= DLY)}, 32'h1);
        end
        tend(4);
        rst <= 1'h1;
        fuses <= 3'h2;
        aon <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        wt(1'h0, 1'h0, 300);
        chk({31'h0, vref}, 32'h1);
        wr(8'h00, 32'h40);
        rd(8'h00, 32'h08, 32'h48);
        src(2'h2, 4'h4);
        repeat (2) @(posedge clk);
        chk({31'h0, port_rst}, 32'h1);
        wt(1'h0, 1'h0, 300);
        tend(5);
        test_done;
    end
    initial
    begin
        #760000;
        fail("watchdog expired");
        test_done;
    end
endmodule // reset_and_watchdog_control_tb
`default_nettype wire
